//--- logic/fsbdp_pkg.sv
// constants for the front-side bus data-phase block
// assumes a 25 MHz core clock and a bus clock sampled as a plain input
package fsbdp_pkg;
  localparam int GROUPS = 4;
  localparam int GROUP_W = 16;
  localparam int DATA_W = GROUPS * GROUP_W;
  // a group is inverted when more than this many bits would toggle
  localparam int INV_LIMIT = GROUP_W / 2;
  localparam int MCLK_NS = 40;
  localparam int LINK_NS = 320;
  // cycles of mclk per bus clock, and strobe count at which the strobe fires, five cycles after the detected bus edge
  localparam int LINK_CYC = LINK_NS / MCLK_NS;
  localparam int STB_DLY = LINK_CYC / 2;
  localparam int STB_CNT_W = 4;
  localparam int FIFO_DEPTH = 16;
  localparam logic [DATA_W-1:0] BUS_RST = 64'h0000_0000_0000_0000;
endpackage

//--- logic/fsbdp_fifo.sv
// first-word fall-through fifo with a registered read word
// assumes one clock and an asynchronous, synchronously released reset
module fsbdp_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 16
) (
  input wire logic clk, // core clock
  input wire logic rst_n, // active low reset
  input wire logic in_valid, // word offered
  output logic in_ready, // room for a word
  input wire logic [WIDTH-1:0] in_data, // word written
  output logic out_valid, // word available
  input wire logic out_ready, // word taken
  output logic [WIDTH-1:0] out_data // registered read word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wptr_q;
  logic [AW-1:0] rptr_q;
  logic [AW:0] cnt_q;
  logic push;
  logic load;
  logic ovalid_q;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign push = in_valid && in_ready;
  assign load = (cnt_q != '0) && (!ovalid_q || out_ready);
  assign out_valid = ovalid_q;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wptr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wptr_q <= wptr_q + 1'b1;
      end
      if (load) begin
        rptr_q <= rptr_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(load);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ovalid_q <= 1'b0;
      out_data <= '0;
    end else if (load) begin
      ovalid_q <= 1'b1;
      out_data <= mem_q[rptr_q];
    end else if (out_ready) begin
      ovalid_q <= 1'b0;
    end
  end
endmodule

//--- logic/fsbdp_data_phase.sv
// data-phase signalling of a front-side bus: inversion, data valid,
// negative strobes, order_postpone_n and input-buffer power request
// assumes the bus clock, pins and strobes arrive asynchronously to mclk
module fsbdp_data_phase #(
  parameter int GROUPS = fsbdp_pkg::GROUPS,
  parameter int GROUP_W = fsbdp_pkg::GROUP_W,
  parameter int FIFO_DEPTH = fsbdp_pkg::FIFO_DEPTH
) (
  input wire logic mclk, // core clock
  input wire logic resetn, // async reset, active low
  input wire logic link_clk, // bus clock pin
  input wire logic tx_own, // we drive the data bus
  input wire logic tx_valid, // transmit word offered
  output logic tx_ready, // transmit fifo has room
  input wire logic [GROUPS*GROUP_W-1:0] tx_data, // transmit word
  output logic rx_valid, // received word pulse
  output logic [GROUPS*GROUP_W-1:0] rx_data, // received word
  output logic deferred, // order_postpone_n seen at bus edge, pulse
  output logic buf_power_down, // chipset asks buffers off
  input wire logic [GROUPS*GROUP_W-1:0] bus_data_i, // data pins in
  output logic [GROUPS*GROUP_W-1:0] bus_data_o, // data pins out
  output logic bus_data_oe, // data pins drive
  input wire logic [GROUPS-1:0] group_invert_n_i, // inversion in
  output logic [GROUPS-1:0] group_invert_n_o, // inversion out
  output logic group_invert_n_oe, // inversion drive
  input wire logic data_valid_n_i, // data valid in
  output logic data_valid_n_o, // data valid out
  output logic data_valid_n_oe, // data valid drive
  input wire logic [GROUPS-1:0] neg_data_strobe_n_i, // strobes in
  output logic [GROUPS-1:0] neg_data_strobe_n_o, // strobes out
  output logic neg_data_strobe_n_oe, // strobes drive
  input wire logic order_postpone_n, // order_postpone_n pin
  input wire logic input_buffer_power_n // buffer power pin
);
  localparam int DW = GROUPS * GROUP_W;
  localparam int CW = fsbdp_pkg::STB_CNT_W;

  function automatic logic needs_invert(input logic [GROUP_W-1:0] a,
                                        input logic [GROUP_W-1:0] b);
    int n;
    n = 0;
    for (int i = 0; i < GROUP_W; i++) begin
      n = n + int'(a[i] ^ b[i]);
    end
    return n > fsbdp_pkg::INV_LIMIT;
  endfunction

  // --------------------------------------------------------------
  // reset release and pin synchronisers
  // --------------------------------------------------------------
  logic rst_s1_q;
  logic rst_n;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  logic lk_s1_q, lk_s2_q, lk_s3_q;
  logic [DW-1:0] d_s1_q, d_s2_q;
  logic [GROUPS-1:0] inv_s1_q, inv_s2_q;
  logic [GROUPS-1:0] stb_s1_q, stb_s2_q, stb_s3_q;
  logic dv_s1_q, dv_s2_q;
  logic df_s1_q, df_s2_q;
  logic pw_s1_q, pw_s2_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      {lk_s1_q, lk_s2_q, lk_s3_q} <= 3'h7;
      d_s1_q <= '0;
      d_s2_q <= '0;
      inv_s1_q <= '1;
      inv_s2_q <= '1;
      stb_s1_q <= '1;
      stb_s2_q <= '1;
      stb_s3_q <= '1;
      {dv_s1_q, dv_s2_q} <= 2'h3;
      {df_s1_q, df_s2_q} <= 2'h3;
      {pw_s1_q, pw_s2_q} <= 2'h3;
    end else begin
      {lk_s1_q, lk_s2_q, lk_s3_q} <= {link_clk, lk_s1_q, lk_s2_q};
      d_s1_q <= bus_data_i;
      d_s2_q <= d_s1_q;
      inv_s1_q <= group_invert_n_i;
      inv_s2_q <= inv_s1_q;
      stb_s1_q <= neg_data_strobe_n_i;
      stb_s2_q <= stb_s1_q;
      stb_s3_q <= stb_s2_q;
      {dv_s1_q, dv_s2_q} <= {data_valid_n_i, dv_s1_q};
      {df_s1_q, df_s2_q} <= {order_postpone_n, df_s1_q};
      {pw_s1_q, pw_s2_q} <= {input_buffer_power_n, pw_s1_q};
    end
  end

  logic lk_rise;
  assign lk_rise = lk_s2_q && !lk_s3_q;

  // --------------------------------------------------------------
  // transmit fifo
  // --------------------------------------------------------------
  logic f_valid;
  logic f_pop;
  logic [DW-1:0] f_data;
  assign f_pop = lk_rise && tx_own && f_valid;

  fsbdp_fifo #(
    .WIDTH(DW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(mclk),
    .rst_n(rst_n),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data(tx_data),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data(f_data)
  );

  // --------------------------------------------------------------
  // transmit: inversion coding, data valid, strobes
  // --------------------------------------------------------------
  logic [DW-1:0] enc_d;
  logic [GROUPS-1:0] enc_inv;
  always_comb begin
    for (int g = 0; g < GROUPS; g++) begin
      enc_inv[g] = needs_invert(f_data[g*GROUP_W +: GROUP_W],
                                bus_data_o[g*GROUP_W +: GROUP_W]);
      enc_d[g*GROUP_W +: GROUP_W] = enc_inv[g] ? ~f_data[g*GROUP_W +: GROUP_W]
                                               : f_data[g*GROUP_W +: GROUP_W];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bus_data_o <= DW'(fsbdp_pkg::BUS_RST);
      group_invert_n_o <= '1;
      data_valid_n_o <= 1'b1;
    end else if (lk_rise) begin
      if (f_pop) begin
        bus_data_o <= enc_d;
        group_invert_n_o <= ~enc_inv;
        data_valid_n_o <= 1'b0;
      end else begin
        data_valid_n_o <= 1'b1; // idle clock
      end
    end
  end

  logic oe_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= tx_own;
    end
  end
  assign bus_data_oe = oe_q;
  assign group_invert_n_oe = oe_q;
  assign data_valid_n_oe = oe_q;
  assign neg_data_strobe_n_oe = oe_q;

  logic [CW-1:0] stb_cnt_q;
  logic stb_arm_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stb_cnt_q <= '0;
      stb_arm_q <= 1'b0;
      neg_data_strobe_n_o <= '1;
    end else begin
      neg_data_strobe_n_o <= '1;
      if (f_pop) begin
        stb_arm_q <= 1'b1;
        stb_cnt_q <= '0;
      end else if (stb_arm_q) begin
        stb_cnt_q <= stb_cnt_q + 1'b1;
        if (stb_cnt_q == CW'(fsbdp_pkg::STB_DLY)) begin
          stb_arm_q <= 1'b0;
          neg_data_strobe_n_o <= '0; // all group strobes at once, five mclk cycles after data and inversion change
        end
      end
    end
  end

  // --------------------------------------------------------------
  // receive: per-group strobe capture, accept on valid clocks
  // --------------------------------------------------------------
  logic [DW-1:0] grp_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      grp_q <= '0;
    end else if (!tx_own) begin
      for (int g = 0; g < GROUPS; g++) begin
        if (!stb_s2_q[g] && stb_s3_q[g]) begin
          grp_q[g*GROUP_W +: GROUP_W] <= inv_s2_q[g] ? d_s2_q[g*GROUP_W +: GROUP_W]
                                                     : ~d_s2_q[g*GROUP_W +: GROUP_W];
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_valid <= 1'b0;
      rx_data <= '0;
      deferred <= 1'b0;
      buf_power_down <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      deferred <= lk_rise && !df_s2_q;
      buf_power_down <= !pw_s2_q;
      if (lk_rise && !tx_own && !dv_s2_q) begin
        rx_valid <= 1'b1;
        rx_data <= grp_q;
      end
    end
  end
endmodule

//--- sim/fsbdp_data_phase_asserts.sv
// pin checks for the data-phase block
// assumes a bind into fsbdp_data_phase
module fsbdp_data_phase_asserts #(
  parameter int GROUPS = 4,
  parameter int GROUP_W = 16
) (
  input wire logic mclk, // clock
  input wire logic resetn, // reset
  input wire logic tx_own, // drive request
  input wire logic rx_valid, // rx pulse
  input wire logic deferred, // order_postpone_n pulse
  input wire logic buf_power_down, // power request
  input wire logic input_buffer_power_n, // power pin
  input wire logic [GROUPS*GROUP_W-1:0] bus_data_o, // data out
  input wire logic bus_data_oe, // data drive
  input wire logic [GROUPS-1:0] neg_data_strobe_n_o // strobes
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  property p_oe; tx_own |=> bus_data_oe; endproperty
  a_oe: assert property (p_oe) else $error("drive enable lag");
  property p_stb; $fell(neg_data_strobe_n_o[0]) |=> &neg_data_strobe_n_o; endproperty
  a_stb: assert property (p_stb) else $error("strobe width");
  property p_grp; (&neg_data_strobe_n_o) || !(|neg_data_strobe_n_o); endproperty
  a_grp: assert property (p_grp) else $error("strobes split");
  property p_lag; $changed(bus_data_o) |-> ##5 !(|neg_data_strobe_n_o); endproperty
  a_lag: assert property (p_lag) else $error("strobe timing");
  property p_inv0;
    $changed(bus_data_o) |-> $countones(bus_data_o[15:0] ^ $past(bus_data_o[15:0])) <= 8;
  endproperty
  a_inv0: assert property (p_inv0) else $error("low group toggles");
  property p_inv3;
    $changed(bus_data_o) |-> $countones(bus_data_o[63:48] ^ $past(bus_data_o[63:48])) <= 8;
  endproperty
  a_inv3: assert property (p_inv3) else $error("top group toggles");
  property p_def; deferred |=> !deferred; endproperty
  a_def: assert property (p_def) else $error("order_postpone_n width");
  property p_pwr; !input_buffer_power_n [*4] |-> buf_power_down; endproperty
  a_pwr: assert property (p_pwr) else $error("power request");
  property p_rx; rx_valid |-> !bus_data_oe; endproperty
  a_rx: assert property (p_rx) else $error("rx while driving");
endmodule
bind fsbdp_data_phase fsbdp_data_phase_asserts #(.GROUPS(GROUPS), .GROUP_W(GROUP_W)) u_chk (
  .mclk, .resetn, .tx_own, .rx_valid, .deferred, .buf_power_down, .input_buffer_power_n,
  .bus_data_o, .bus_data_oe, .neg_data_strobe_n_o);

//--- sim/fsbdp_far_agent.sv
// far bus agent: drives data, inversion, valid and strobes
// assumes the bench muxes pins by the block's drive enables
module fsbdp_far_agent (
  input wire logic link_clk, // bus clock
  output logic [63:0] data_o, // data
  output logic [3:0] inv_n_o, // inversion
  output logic valid_n_o, // data valid
  output logic [3:0] stb_n_o // strobes
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [63:0] last_q = '0;
  initial begin
    data_o = '1;
    inv_n_o = '1;
    valid_n_o = 1'b1;
    stb_n_o = '1;
  end
  task automatic send(input logic [63:0] w, input logic v);
    logic [15:0] t;
    @(posedge link_clk);
    #80;
    for (int g = 0; g < 4; g++) begin
      t = w[16*g+:16];
      inv_n_o[g] = !($countones(t ^ last_q[16*g+:16]) > 8);
      data_o[16*g+:16] = inv_n_o[g] ? t : ~t;
    end
    last_q = data_o;
    valid_n_o = !v;
    @(negedge link_clk);
    stb_n_o = '0;
    #80 stb_n_o = '1;
  endtask
  task automatic release_bus;
    @(posedge link_clk);
    #80;
    data_o = ~last_q;
    inv_n_o = ~inv_n_o;
    valid_n_o = 1'b1;
  endtask
endmodule

//--- sim/fsbdp_data_phase_tb.sv
// self-checking bench for the data-phase block
// assumes the far agent model and the bound checker
module fsbdp_data_phase_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 0, resetn = 0, link_clk = 0, tx_own = 0, tx_valid = 0;
  logic order_postpone_n = 1, input_buffer_power_n = 1;
  logic [63:0] tx_data = '0, rx_data, bus_data_o, f_data;
  logic [3:0] group_invert_n_o, neg_data_strobe_n_o, f_inv, f_stb;
  logic tx_ready, rx_valid, deferred, buf_power_down, bus_data_oe, data_valid_n_o, f_vld;
  logic group_invert_n_oe, data_valid_n_oe, neg_data_strobe_n_oe;
  logic [63:0] rxq[$];
  int err_count = 0, tests_run = 0, n_def = 0;
  int timed_out = 0;
  wire [63:0] bus_data_i = bus_data_oe ? bus_data_o : f_data;
  wire [3:0] group_invert_n_i = group_invert_n_oe ? group_invert_n_o : f_inv;
  wire data_valid_n_i = data_valid_n_oe ? data_valid_n_o : f_vld;
  wire [3:0] neg_data_strobe_n_i = neg_data_strobe_n_oe ? neg_data_strobe_n_o : f_stb;
  fsbdp_data_phase DUT (.mclk, .resetn, .link_clk, .tx_own, .tx_valid, .tx_ready, .tx_data,
    .rx_valid, .rx_data, .deferred, .buf_power_down, .bus_data_i, .bus_data_o, .bus_data_oe,
    .group_invert_n_i, .group_invert_n_o, .group_invert_n_oe, .data_valid_n_i,
    .data_valid_n_o, .data_valid_n_oe, .neg_data_strobe_n_i, .neg_data_strobe_n_o,
    .neg_data_strobe_n_oe, .order_postpone_n, .input_buffer_power_n);
  fsbdp_far_agent far (.link_clk, .data_o(f_data), .inv_n_o(f_inv), .valid_n_o(f_vld),
    .stb_n_o(f_stb));
  initial forever #20 mclk = ~mclk;
  initial begin
    #7;
    forever #160 link_clk = ~link_clk;
  end
  always @(negedge mclk) begin
    if (rx_valid === 1'b1) rxq.push_back(rx_data);
    if (deferred === 1'b1) n_def++;
  end
  function automatic logic [63:0] word(input int i);
    return (i[0] ? 64'hFFFF_01FF_00FF_8000 : 64'h0000_0000_0000_0000) ^ {4{16'(i)}};
  endfunction
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic t_tx;
    logic [63:0] prev, exp;
    logic [15:0] t;
    logic [3:0] inv;
    int n;
    prev = '0;
    for (n = 0; n < 20 && tx_ready === 1'b1; n++) begin
      tx_data = word(n);
      tx_valid = 1;
      @(negedge mclk);
    end
    tx_valid = 0;
    chk("fifo fill", 64'(17), 64'(n));
    tx_own = 1;
    @(negedge mclk);
    chk("drive enables", 64'h000F, 64'({bus_data_oe, group_invert_n_oe, data_valid_n_oe,
      neg_data_strobe_n_oe}));
    for (int i = 0; i < 17; i++) begin
      for (n = 0; n < 40 && neg_data_strobe_n_o !== 4'h0; n++) @(negedge mclk);
      if (n == 40) begin
        chk("strobe wait", 64'h0000, 64'h0001);
        timed_out = 1;
        tx_own = 0;
        return;
      end
      for (int g = 0; g < 4; g++) begin
        t = 16'(word(i) >> (16 * g));
        inv[g] = !($countones(t ^ prev[16*g+:16]) > 8);
        exp[16*g+:16] = inv[g] ? t : ~t;
      end
      chk("tx data", exp, bus_data_o);
      chk("tx invert", 64'(inv), 64'(group_invert_n_o));
      chk("tx valid", 0, 64'(data_valid_n_o));
      prev = exp;
      @(negedge mclk);
    end
    for (n = 0; n < 20 && data_valid_n_o !== 1'b1; n++) @(negedge mclk);
    if (n == 20) timed_out = 1;
    chk("idle valid", 1, 64'(data_valid_n_o));
    tx_own = 0;
    @(negedge mclk);
    chk("release enables", 64'h0000, 64'({bus_data_oe, group_invert_n_oe, data_valid_n_oe,
      neg_data_strobe_n_oe}));
  endtask
  task automatic t_rx;
    rxq = {};
    far.send(64'hFFFF_FFFF_0000_1234, 1);
    far.send(64'h5A5A_5A5A_5A5A_5A5A, 0);
    far.send(64'h0000_FFFF_F0F0_0001, 1);
    far.release_bus();
    repeat (16) @(negedge mclk);
    chk("rx count", 2, 64'(rxq.size()));
    chk("rx word", 64'hFFFF_FFFF_0000_1234, rxq[0]);
    chk("rx word", 64'h0000_FFFF_F0F0_0001, rxq[1]);
  endtask
  task automatic t_side;
    n_def = 0;
    @(negedge link_clk) order_postpone_n = 0;
    @(negedge link_clk) order_postpone_n = 1;
    repeat (8) @(negedge mclk);
    chk("order_postpone_n pulses", 1, 64'(n_def));
    input_buffer_power_n = 0;
    repeat (5) @(negedge mclk);
    chk("power down", 1, 64'(buf_power_down));
    input_buffer_power_n = 1;
    repeat (5) @(negedge mclk);
    chk("power up", 0, 64'(buf_power_down));
  endtask
  initial begin
    repeat (16) @(negedge mclk);
    resetn = 1;
    repeat (4) @(negedge mclk);
    t_tx();
    $display("test tx done");
    if (timed_out == 0) begin
      t_rx();
      $display("test rx done");
      t_side();
      $display("test side done");
    end
    final_report();
  end
endmodule
